// ---- common/blk_tx_pkg.sv ----
// Purpose: Constants for the block-transmit packet formatter (host side)
// Assumes: 32-bit quadlets, header of four quadlets
// Notes:   Field positions are bit offsets inside a quadlet
package blk_tx_pkg;

  // ----------------------------------------
  // Speed codes
  // ----------------------------------------
  localparam logic [1:0] SPD_S100 = 2'h0;
  localparam logic [1:0] SPD_S200 = 2'h1;
  localparam logic [1:0] SPD_S400 = 2'h2;
  localparam logic [1:0] SPD_BAD  = 2'h3;

  // ----------------------------------------
  // Retry codes
  // ----------------------------------------
  localparam logic [1:0] RT_NEW    = 2'h0;
  localparam logic [1:0] RT_RETRYX = 2'h1;
  localparam logic [1:0] RT_RETRYA = 2'h2;
  localparam logic [1:0] RT_RETRYB = 2'h3;

  // ----------------------------------------
  // Response codes
  // ----------------------------------------
  localparam logic [3:0] RC_COMPLETE = 4'h0;
  localparam logic [3:0] RC_CONFLICT = 4'h4;
  localparam logic [3:0] RC_DATA_ERR = 4'h5;
  localparam logic [3:0] RC_TYPE_ERR = 4'h6;
  localparam logic [3:0] RC_ADDR_ERR = 4'h7;

  // ----------------------------------------
  // Quadlet 0 field positions
  // ----------------------------------------
  localparam int SPD_LSB   = 30;
  localparam int LABEL_LSB = 10;
  localparam int RT_LSB    = 8;
  localparam int TCODE_LSB = 4;
  localparam int PRIO_LSB  = 0;

  // ----------------------------------------
  // Quadlet 1..3 field positions
  // ----------------------------------------
  localparam int DEST_LSB  = 16;
  localparam int NODE_LSB  = 16;
  localparam int BUS_LSB   = 22;
  localparam int RCODE_LSB = 12;
  localparam int LEN_LSB   = 16;
  localparam int EXT_LSB   = 0;

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int HDR_QUADS  = 4;
  localparam int QUAD_BYTES = 4;
  localparam logic [1:0] ALIGN_MASK = 2'h3;
  localparam logic [3:0] TCODE_BLK_WR   = 4'h1;
  localparam logic [3:0] TCODE_BLK_RESP = 4'h7;
  localparam logic [3:0] TCODE_LOCK_RESP = 4'hb;

endpackage

// ---- common/quad_stream_if.sv ----
// Purpose: Quadlet stream between header builder and the push sequencer
// Assumes: One clock domain
// Notes:   Valid/ready handshake, word taken when both high
`timescale 1ns/1ps
interface quad_stream_if;
  logic        valid;
  logic        ready;
  logic [31:0] data;
  logic        last;
  modport src (output valid, output data, output last, input ready);
  modport snk (input valid, input data, input last, output ready);
endinterface

// ---- design/blk_hdr_builder.sv ----
// Purpose: Builds the four header quadlets of a block-transmit packet
// Assumes: Request fields are stable while building
// Notes:   Pure combinational packing, indexed by quadlet number
`timescale 1ns/1ps
module blk_hdr_builder
  import blk_tx_pkg::*;
(
  // Request fields
  input  wire logic [1:0]  spd_in,
  input  wire logic [5:0]  label_in,
  input  wire logic [1:0]  rt_in,
  input  wire logic [3:0]  tcode_in,
  input  wire logic [9:0]  bus_in,
  input  wire logic [5:0]  node_in,
  input  wire logic [47:0] offset_in,
  input  wire logic [3:0]  rcode_in,
  input  wire logic [15:0] len_in,
  input  wire logic [15:0] ext_in,
  // Selection
  input  wire logic [1:0]  idx_in,
  output logic      [31:0] quad_out
);

  logic        lock_resp;
  logic [15:0] off_hi;

  // ----------------------------------------
  // Field packing
  // ----------------------------------------
  assign lock_resp = (tcode_in == TCODE_LOCK_RESP) || (tcode_in == TCODE_BLK_RESP);
  // Response code rides in the top of the high offset, rest zero
  assign off_hi = lock_resp ? {rcode_in, 12'h000} : offset_in[47:32];

  always_comb
  begin
    unique case (idx_in)
      2'h0:
      begin
        // Priority bits forced to zero for cable use
        quad_out = (32'(spd_in) << SPD_LSB) | (32'(label_in) << LABEL_LSB)
                 | (32'(rt_in) << RT_LSB) | (32'(tcode_in) << TCODE_LSB);
      end
      2'h1:    quad_out = {bus_in, node_in, off_hi};
      2'h2:    quad_out = {offset_in[31:2], 2'h0};
      default: quad_out = (32'(len_in) << LEN_LSB) | 32'(ext_in);
    endcase
  end

endmodule

// ---- design/blk_tx_host.sv ----
// Purpose: Host side that writes block-transmit packets into the link FIFO
// Assumes: Link FIFO accepts a quadlet when fifo_wr_out and fifo_ready_in are high
// Notes:   Payload quadlets come from the user stream, byte 0 first
`timescale 1ns/1ps

// Summary of operation
// - Speed code 00/01/10 only, never 11
// - User supplies unique transaction label
// - Retry field new, X, A, B encoding
// - Priority bits written as zero
// - Destination is bus number then node
// - Destination offset forced quadlet aligned
// - Lock response code in upper offset bits
// - Data length equals payload byte count
// - Zero length writes no data quadlets
// - First payload byte in lane zero
// - Extended code from user request
// - Four header quadlets in fixed layout
// - Response codes 0,4..7 only accepted on responses
module blk_tx_host
  import blk_tx_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        arst_n_in,
  // Packet request
  input  wire logic        req_valid_in,
  output logic             req_ready_out,
  input  wire logic [1:0]  spd_in,
  input  wire logic [5:0]  label_in,
  input  wire logic [1:0]  rt_in,
  input  wire logic [3:0]  tcode_in,
  input  wire logic [9:0]  bus_in,
  input  wire logic [5:0]  node_in,
  input  wire logic [47:0] offset_in,
  input  wire logic [3:0]  rcode_in,
  input  wire logic [15:0] len_in,
  input  wire logic [15:0] ext_in,
  output logic             req_err_out,
  // Payload stream
  input  wire logic        pay_valid_in,
  output logic             pay_ready_out,
  input  wire logic [31:0] pay_data_in,
  // Link transmit FIFO
  output logic             fifo_wr_out,
  output logic      [31:0] fifo_data_out,
  output logic             fifo_last_out,
  input  wire logic        fifo_ready_in
);

  typedef enum logic [1:0] {ST_IDLE, ST_HDR, ST_DATA} state_t;

  state_t      state_q;
  logic [1:0]  spd_q;
  logic [5:0]  label_q;
  logic [1:0]  rt_q;
  logic [3:0]  tcode_q;
  logic [9:0]  bus_q;
  logic [5:0]  node_q;
  logic [47:0] offset_q;
  logic [3:0]  rcode_q;
  logic [15:0] len_q;
  logic [15:0] ext_q;
  logic [1:0]  hidx_q;
  logic [14:0] dleft_q;
  logic        err_q;
  logic [31:0] hdr_quad;
  logic [31:0] data_q;
  logic        wr_q;
  logic        last_q;
  logic        req_ok;
  logic        rc_ok;
  logic        lock_resp;
  logic [14:0] quads_of_len;
  logic        out_free;

  quad_stream_if hdr_if ();

  // ----------------------------------------
  // Request check
  // ----------------------------------------
  assign lock_resp = (tcode_in == TCODE_LOCK_RESP) || (tcode_in == TCODE_BLK_RESP);
  // Reserved response codes rejected on responses
  assign rc_ok = !lock_resp || (rcode_in == RC_COMPLETE) || (rcode_in == RC_CONFLICT)
               || (rcode_in == RC_DATA_ERR) || (rcode_in == RC_TYPE_ERR)
               || (rcode_in == RC_ADDR_ERR);
  assign req_ok = (spd_in != SPD_BAD) && rc_ok;
  // Rounded up so a partial last quadlet is still sent; one spare bit so
  // the largest lengths do not wrap to an empty payload
  assign quads_of_len = 15'((17'(len_in) + 17'(QUAD_BYTES - 1)) >> 2);
  // Output slot is free when empty or being drained this cycle
  assign out_free = !wr_q || fifo_ready_in;
  assign req_ready_out = (state_q == ST_IDLE);

  // ----------------------------------------
  // Header packing
  // ----------------------------------------
  blk_hdr_builder u_hdr (
    .spd_in    (spd_q),
    .label_in  (label_q),
    .rt_in     (rt_q),
    .tcode_in  (tcode_q),
    .bus_in    (bus_q),
    .node_in   (node_q),
    .offset_in (offset_q),
    .rcode_in  (rcode_q),
    .len_in    (len_q),
    .ext_in    (ext_q),
    .idx_in    (hidx_q),
    .quad_out  (hdr_quad)
  );

  assign hdr_if.valid = (state_q == ST_HDR);
  assign hdr_if.data  = hdr_quad;
  assign hdr_if.last  = (hidx_q == 2'(HDR_QUADS - 1)) && (dleft_q == '0);
  assign hdr_if.ready = out_free;

  assign pay_ready_out = (state_q == ST_DATA) && out_free;

  // ----------------------------------------
  // Request capture
  // ----------------------------------------
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      spd_q    <= SPD_S100;
      label_q  <= '0;
      rt_q     <= RT_NEW;
      tcode_q  <= TCODE_BLK_WR;
      bus_q    <= '0;
      node_q   <= '0;
      offset_q <= '0;
      rcode_q  <= RC_COMPLETE;
      len_q    <= '0;
      ext_q    <= '0;
    end
    else if (req_valid_in && req_ready_out && req_ok)
    begin
      spd_q    <= spd_in;
      label_q  <= label_in;
      rt_q     <= rt_in;
      tcode_q  <= tcode_in;
      bus_q    <= bus_in;
      node_q   <= node_in;
      offset_q <= offset_in;
      rcode_q  <= rcode_in;
      len_q    <= len_in;
      ext_q    <= ext_in;
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      state_q <= ST_IDLE;
      hidx_q  <= '0;
      dleft_q <= '0;
    end
    else
    begin
      unique case (state_q)
        ST_IDLE:
        begin
          if (req_valid_in && req_ok)
          begin
            state_q <= ST_HDR;
            hidx_q  <= '0;
            dleft_q <= quads_of_len;
          end
        end
        ST_HDR:
        begin
          if (hdr_if.valid && hdr_if.ready)
          begin
            hidx_q <= hidx_q + 2'h1;
            if (hidx_q == 2'(HDR_QUADS - 1))
            begin
              // No data phase for an empty payload
              state_q <= (dleft_q == '0) ? ST_IDLE : ST_DATA;
            end
          end
        end
        ST_DATA:
        begin
          if (pay_valid_in && pay_ready_out)
          begin
            dleft_q <= dleft_q - 15'h1;
            if (dleft_q == 15'h1)
            begin
              state_q <= ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Error flag
  // ----------------------------------------
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      err_q <= 1'b0;
    end
    else
    begin
      err_q <= req_valid_in && req_ready_out && !req_ok;
    end
  end
  assign req_err_out = err_q;

  // ----------------------------------------
  // FIFO write register
  // ----------------------------------------
  // Quadlets are pushed as the slot frees; link stalls or payload gaps leave idle cycles within a packet
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      wr_q   <= 1'b0;
      data_q <= '0;
      last_q <= 1'b0;
    end
    else if (out_free)
    begin
      wr_q <= 1'b0;
      if (hdr_if.valid)
      begin
        wr_q   <= 1'b1;
        data_q <= hdr_if.data;
        last_q <= hdr_if.last;
      end
      else if (pay_valid_in && pay_ready_out)
      begin
        wr_q   <= 1'b1;
        data_q <= pay_data_in;
        last_q <= (dleft_q == 15'h1);
      end
    end
  end

  assign fifo_wr_out   = wr_q;
  assign fifo_data_out = data_q;
  assign fifo_last_out = last_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_spd_legal: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    (state_q != ST_IDLE) |-> (spd_q != SPD_BAD))
    else $error("illegal speed code in flight");

  chk_prio_zero: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    (fifo_wr_out && $past(state_q) == ST_HDR && $past(hidx_q) == 2'h0)
      |-> (fifo_data_out[3:0] == 4'h0))
    else $error("priority bits not zero");

  chk_off_align: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    (state_q == ST_HDR && hidx_q == 2'h2) |-> (hdr_quad[1:0] == 2'h0))
    else $error("destination offset not aligned");

  chk_zero_len: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    (state_q == ST_DATA) |-> (len_q != 16'h0))
    else $error("data phase entered for zero length");

  chk_hdr_order: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    (state_q == ST_HDR && hdr_if.ready && hidx_q == 2'h0)
      |=> (hidx_q == 2'h1) && (state_q == ST_HDR))
    else $error("header quadlet order broken");

  chk_len_count: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    ($rose(state_q == ST_DATA)) |-> (dleft_q == 15'((17'(len_q) + 17'h3) >> 2)))
    else $error("data count does not match length");

  chk_rcode_ok: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    (req_valid_in && req_ready_out && lock_resp
      && rcode_in inside {[4'h1:4'h3], [4'h8:4'hf]})
      |=> req_err_out && state_q == ST_IDLE)
    else $error("reserved response code accepted");

  chk_last_mark: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    (fifo_wr_out && fifo_last_out) |-> (state_q != ST_DATA))
    else $error("last quadlet marked early");

  // A stalled link must see the same quadlet again on the next cycle
  chk_wr_hold: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    (fifo_wr_out && !fifo_ready_in)
      |=> fifo_wr_out && $stable(fifo_data_out) && $stable(fifo_last_out))
    else $error("quadlet dropped while link stalled");

endmodule

// ---- testbench/blk_tx_host_test.sv ----
// Purpose: Self-checking bench for the block-transmit host formatter
// Assumes: Inputs change on the falling edge; outputs settle before it
// Notes:   Payload word i of row k is {k, a5, i} so lanes stay traceable
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin error_cnt++; $display("Error t=%0t got %0h exp %0h", $time, (g), (e)); end end
module blk_tx_host_test;
  import blk_tx_pkg::*;
  typedef struct packed {
    logic [1:0] spd; logic [1:0] rt; logic [3:0] tcode; logic [3:0] rcode;
    logic [47:0] off; logic [15:0] len; logic err;
  } row_t;
  logic core_clk_in = 0, arst_n = 0, req_valid = 0, pay_valid = 0, stall = 0;
  logic [1:0] spd = 0, rt = 0;
  logic [3:0] tcode = 0, rcode = 0;
  logic [5:0] label = 0, node = 0;
  logic [9:0] bus = 0;
  logic [47:0] offset = 0;
  logic [15:0] len = 0, ext = 0;
  logic [31:0] pay_data = 0, fifo_data;
  logic req_ready, req_err, pay_ready, fifo_wr, fifo_last, fifo_ready;
  int error_cnt = 0, check_count = 0, bad_cnt, pkt_cnt;

  // ----------------------------------------
  // Cases: new, retry X/A/B, every speed and response code; last three rows are rejected requests
  // ----------------------------------------
  row_t rows [9] = '{
    '{SPD_S100, RT_NEW,    TCODE_BLK_WR,    RC_COMPLETE, 48'h1234_5678_9abf, 16'h8, 1'b0},
    '{SPD_S200, RT_RETRYX, TCODE_BLK_RESP,  RC_CONFLICT, 48'hffff_0000_0010, 16'h5, 1'b0},
    '{SPD_S400, RT_RETRYA, TCODE_LOCK_RESP, RC_ADDR_ERR, 48'h0000_0000_0004, 16'h0, 1'b0},
    '{SPD_S100, RT_RETRYB, TCODE_BLK_RESP,  RC_COMPLETE, 48'h0001_0000_0000, 16'h4, 1'b0},
    '{SPD_S200, RT_NEW,    TCODE_BLK_RESP,  RC_DATA_ERR, 48'h0002_0000_0008, 16'h1, 1'b0},
    '{SPD_S400, RT_NEW,    TCODE_LOCK_RESP, RC_TYPE_ERR, 48'h0003_0000_000c, 16'hc, 1'b0},
    '{SPD_BAD,  RT_NEW,    TCODE_BLK_WR,    RC_COMPLETE, 48'h0, 16'h4, 1'b1},
    '{SPD_S100, RT_NEW,    TCODE_BLK_RESP,  4'h1,        48'h0, 16'h4, 1'b1},
    '{SPD_S100, RT_NEW,    TCODE_LOCK_RESP, 4'h8,        48'h0, 16'h4, 1'b1}
  };

  blk_tx_host uut (
    .core_clk_in(core_clk_in), .arst_n_in(arst_n), .req_valid_in(req_valid),
    .req_ready_out(req_ready), .spd_in(spd), .label_in(label), .rt_in(rt), .tcode_in(tcode),
    .bus_in(bus), .node_in(node), .offset_in(offset), .rcode_in(rcode), .len_in(len),
    .ext_in(ext), .req_err_out(req_err), .pay_valid_in(pay_valid), .pay_ready_out(pay_ready),
    .pay_data_in(pay_data), .fifo_wr_out(fifo_wr), .fifo_data_out(fifo_data),
    .fifo_last_out(fifo_last), .fifo_ready_in(fifo_ready));
  link_fifo_model link (
    .clk_in(core_clk_in), .arst_n_in(arst_n), .stall_in(stall), .wr_in(fifo_wr),
    .data_in(fifo_data), .last_in(fifo_last), .ready_out(fifo_ready),
    .bad_cnt_out(bad_cnt), .pkt_cnt_out(pkt_cnt));

  initial
  begin
    forever #25 core_clk_in = ~core_clk_in;
  end

  // Label from the row number keeps every outstanding tag unique
  function automatic logic [31:0] exp_q(input row_t r, input int k, input int i);
    logic [15:0] hi;
    hi = (r.tcode == TCODE_BLK_RESP || r.tcode == TCODE_LOCK_RESP) ? {r.rcode, 12'h000}
                                                                     : r.off[47:32];
    case (i)
      0: exp_q = {r.spd, 14'h0000, 6'(k), r.rt, r.tcode, 4'h0};
      1: exp_q = {10'(k * 37), 6'(k + 1), hi};
      2: exp_q = {r.off[31:2], 2'h0};
      3: exp_q = {r.len, 8'(k), 8'h3c};
      default: exp_q = {8'(k), 8'ha5, 16'(i - 4)};
    endcase
  endfunction

  task automatic complete_run();
    $display("Checks %0d, errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic wait_for(input bit cond, input int lim);
    if (lim <= 0 && !cond)
    begin
      error_cnt++;
      complete_run();
    end
  endtask

  task automatic issue(input int k);
    int n;
    row_t r;
    r = rows[k];
    for (n = 0; req_ready !== 1'b1; n++)
    begin
      wait_for(1'b0, 300 - n);
      @(negedge core_clk_in);
    end
    {spd, rt, tcode, rcode, offset, len} = {r.spd, r.rt, r.tcode, r.rcode, r.off, r.len};
    label = 6'(k);
    bus = 10'(k * 37);
    node = 6'(k + 1);
    ext = {8'(k), 8'h3c};
    req_valid = 1'b1;
    @(negedge core_clk_in);
    req_valid = 1'b0;
  endtask

  task automatic run_row(input int k);
    int n, i, nq;
    logic seen;
    row_t r;
    r = rows[k];
    nq = r.err ? 0 : (int'(r.len) + 3) / 4;
    link.words.delete();
    issue(k);
    seen = req_err;
    @(negedge core_clk_in);
    seen |= req_err;
    `CHK(seen, r.err);
    // Payload only when length is nonzero; first byte rides lane 0
    for (i = 0; i < nq; i++)
    begin
      pay_valid = 1'b1;
      pay_data = exp_q(r, k, i + 4);
      for (n = 0; pay_ready !== 1'b1; n++)
      begin
        wait_for(1'b0, 400 - n);
        @(negedge core_clk_in);
      end
      @(negedge core_clk_in);
    end
    pay_valid = 1'b0;
    for (n = 0; n < 200 && link.words.size() < (r.err ? 0 : 4 + nq); n++)
      @(negedge core_clk_in);
    wait_for(link.words.size() >= (r.err ? 0 : 4 + nq), 200 - n);
    repeat (4) @(negedge core_clk_in);
    `CHK(link.words.size(), r.err ? 0 : 4 + nq);
    for (i = 0; i < link.words.size(); i++)
    begin
      `CHK(link.words[i][31:0] & 32'hc000_ffff, exp_q(r, k, i) & 32'hc000_ffff);
      `CHK(link.words[i][31:16], exp_q(r, k, i) >> 16);
      `CHK(link.words[i][32], 1'(i == 3 + nq));
    end
  endtask

  task automatic chk_idle();
    `CHK({req_ready, req_err, fifo_wr, fifo_last}, 4'h8);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (16) @(negedge core_clk_in);
    arst_n = 1'b1;
    chk_idle();
    for (int k = 0; k < 9; k++)
      run_row(k);
    // Slow FIFO: every quadlet must hold until accepted
    stall = 1'b1;
    run_row(5);
    run_row(1);
    // Reset in mid-packet returns to idle, then a clean packet follows
    issue(0);
    repeat (3) @(negedge core_clk_in);
    arst_n = 1'b0;
    @(negedge core_clk_in);
    chk_idle();
    arst_n = 1'b1;
    stall = 1'b0;
    run_row(0);
    `CHK(bad_cnt, 0);
    `CHK(pkt_cnt, 9);
    complete_run();
  end
endmodule

// ---- testbench/link_fifo_model.sv ----
// Purpose: Link transmit FIFO model that takes formatted block packets
// Assumes: One clock; a word is taken on an edge with write and ready high
// Notes:   Stall mode opens ready one cycle in four, so writes must hold
`timescale 1ns/1ps
module link_fifo_model
  import blk_tx_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        arst_n_in,
  // Control
  input  wire logic        stall_in,
  // FIFO write side
  input  wire logic        wr_in,
  input  wire logic [31:0] data_in,
  input  wire logic        last_in,
  output logic             ready_out,
  // Status
  output int               bad_cnt_out,
  output int               pkt_cnt_out
);
  logic [32:0] words[$];
  logic [1:0]  ph_q;
  logic [31:0] q0;
  logic [31:0] q1;
  logic [31:0] q3;

  // ----------------------------------------
  // Accept and check packets
  // ----------------------------------------
  // Counters survive reset so a mid-run reset cannot hide a bad packet
  initial
  begin
    bad_cnt_out = 0;
    pkt_cnt_out = 0;
  end

  always @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      ready_out <= 1'b0;
      ph_q      <= 2'h0;
    end
    else
    begin
      ph_q      <= ph_q + 2'h1;
      ready_out <= !stall_in || (ph_q == 2'h3);
      if (wr_in && ready_out)
      begin
        words.push_back({last_in, data_in});
        if (last_in)
        begin
          q0 = words[0][31:0];
          q1 = words[1][31:0];
          q3 = words[3][31:0];
          // Sent only once header and announced payload are all present
          if (words.size() != HDR_QUADS + (int'(q3[31:16]) + 3) / 4)
            bad_cnt_out++;
          if (q0[31:30] == SPD_BAD || q0[3:0] != 4'h0)
            bad_cnt_out++;
          if ((q0[7:4] == TCODE_BLK_RESP || q0[7:4] == TCODE_LOCK_RESP)
              && !(q1[15:12] inside {RC_COMPLETE, [RC_CONFLICT:RC_ADDR_ERR]}))
            bad_cnt_out++;
          pkt_cnt_out++;
        end
      end
    end
  end
endmodule
